// ---- src/sixio_pin_sync.sv ----
`timescale 1ns/1ps
module sixio_pin_sync #(
   parameter int unsigned     W          = 6,
   parameter logic [W-1:0]    IDLE_LEVEL = '1
) (
   input  wire logic          clock,
   input  wire logic          rst_n,
   input  wire logic          clock_enable,
   input  wire logic [W-1:0]  async_in,
   output logic      [W-1:0]  level
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
   } sixio_sync_state_t;

   sixio_sync_state_t st_reg;
   sixio_sync_state_t st_next;

   // ---------------------------------------------------------------
   // three stages; accept a change once stages two and three agree
   // ---------------------------------------------------------------
   always_comb
   begin
      st_next       = st_reg;
      st_next.s1    = async_in;
      st_next.s2    = st_reg.s1;
      st_next.s3    = st_reg.s2;
      // stage one feeds only stage two; disagreeing bits keep old level
      st_next.level = (st_reg.s3 & ~(st_reg.s2 ^ st_reg.s3))
                    | (st_reg.level & (st_reg.s2 ^ st_reg.s3));
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= {IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL};
      end
      else if (clock_enable)
      begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.level;

endmodule // sixio_pin_sync

// ---- src/sixio_pkg.sv ----
package sixio_pkg;

   // ---------------------------------------------------------------
   // port geometry
   // ---------------------------------------------------------------
   localparam int unsigned PIN_COUNT = 6;
   localparam int unsigned TOP_PIN   = 5;
   localparam int unsigned REG_W     = 8;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned ADDR_W    = 20;

   // ---------------------------------------------------------------
   // register indices; byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [15:0] IDX_PIN_DIRECTION      = 16'hFEB2;
   localparam logic [15:0] IDX_PIN_LEVEL_READBACK = 16'hFF52;
   localparam logic [15:0] IDX_OUTPUT_VALUE       = 16'hFF62;
   localparam logic [15:0] IDX_OPEN_DRAIN_SELECT  = 16'hFF76;

   localparam logic [ADDR_W-1:0] ADDR_PIN_DIRECTION      = {2'h0, IDX_PIN_DIRECTION, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL_READBACK = {2'h0, IDX_PIN_LEVEL_READBACK, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_OUTPUT_VALUE       = {2'h0, IDX_OUTPUT_VALUE, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_OPEN_DRAIN_SELECT  = {2'h0, IDX_OPEN_DRAIN_SELECT, 2'h0};

   // ---------------------------------------------------------------
   // reset and read values
   // ---------------------------------------------------------------
   localparam logic [PIN_COUNT-1:0] DIRECTION_RST  = 6'h00;
   localparam logic [PIN_COUNT-1:0] OUTPUT_RST     = 6'h00;
   localparam logic [PIN_COUNT-1:0] OPEN_DRAIN_RST = 6'h00;
   localparam logic [PIN_COUNT-1:0] READBACK_RST   = 6'h00;
   localparam logic [PIN_COUNT-1:0] PIN_IDLE_LEVEL = 6'h3F;
   localparam logic [REG_W-1:0]     DIRECTION_READ = 8'hFF;
   localparam logic [1:0]           RESERVED_READ  = 2'h0;

endpackage

// ---- src/sixio_port.sv ----
`timescale 1ns/1ps
module sixio_port #(
   parameter int unsigned PINS = sixio_pkg::PIN_COUNT
) (
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   input  wire logic                          clock_enable,
   input  wire logic                          manual_reset,
   input  wire logic                          hw_standby,
   input  wire logic                          sw_standby,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [sixio_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [sixio_pkg::DATA_W-1:0]  pwdata,
   input  wire logic [3:0]                    pstrb,
   output logic                               pready,
   output logic      [sixio_pkg::DATA_W-1:0]  prdata,
   output logic                               pslverr,
   input  wire logic                          serial_init,
   input  wire logic                          clock_enable_low,
   input  wire logic                          clock_enable_high,
   input  wire logic                          async_sync_select,
   input  wire logic                          serial_clock_ch1_out,
   output logic                               serial_clock_ch1_in,
   output logic                               external_interrupt_line_b,
   input  wire logic [PINS-1:0]               pin_in,
   output logic      [PINS-1:0]               pin_out,
   output logic      [PINS-1:0]               pin_oe
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [PINS-1:0]               pin_direction;
      logic [PINS-1:0]               output_value;
      logic [PINS-1:0]               open_drain_select;
      logic [PINS-1:0]               readback;
      logic [PINS-1:0]               pin_out;
      logic [PINS-1:0]               pin_oe;
      logic                          sck_in;
      logic                          irq_b;
      logic                          pready;
      logic                          pslverr;
      logic [sixio_pkg::DATA_W-1:0]  prdata;
   } sixio_state_t;

   sixio_state_t st_reg;
   sixio_state_t st_next;

   logic [PINS-1:0] pin_level;

   // ---------------------------------------------------------------
   // pin input synchronisers
   // ---------------------------------------------------------------
   // one filter serves both general reads and the interrupt path,
   // so the interrupt line sees the same debounced level as software
   sixio_pin_sync #(
      .W          (PINS),
      .IDLE_LEVEL (sixio_pkg::PIN_IDLE_LEVEL)
   ) u_pin_sync (
      .clock        (clock),
      .rst_n        (rst_n),
      .clock_enable (clock_enable),
      .async_in     (pin_in),
      .level        (pin_level)
   );

   // ---------------------------------------------------------------
   // bus phase and address decode
   // ---------------------------------------------------------------
   logic setup_phase;
   logic access_done;
   logic hit_direction;
   logic hit_readback;
   logic hit_output;
   logic hit_open_drain;
   logic hit_any;
   logic low_lane_write;

   // zero-wait slave: answer is prepared in the setup cycle
   assign setup_phase    = psel & ~penable;
   assign access_done    = psel & penable & st_reg.pready;
   assign hit_direction  = (paddr == sixio_pkg::ADDR_PIN_DIRECTION);
   assign hit_readback   = (paddr == sixio_pkg::ADDR_PIN_LEVEL_READBACK);
   assign hit_output     = (paddr == sixio_pkg::ADDR_OUTPUT_VALUE);
   assign hit_open_drain = (paddr == sixio_pkg::ADDR_OPEN_DRAIN_SELECT);
   assign hit_any        = hit_direction | hit_readback | hit_output | hit_open_drain;
   // registers are eight bits wide, only byte lane zero carries data
   assign low_lane_write = access_done & pwrite & ~st_reg.pslverr & pstrb[0];

   // ---------------------------------------------------------------
   // top pin function select
   // ---------------------------------------------------------------
   logic top_sck_input;
   logic top_sck_output;

   // while the serial channel is held initialised it owns no pin
   always_comb
   begin
      top_sck_input  = 1'b0;
      top_sck_output = 1'b0;
      if (!serial_init)
      begin
         top_sck_input  = clock_enable_high;
         top_sck_output = ~clock_enable_high
                        & (async_sync_select | clock_enable_low);
      end
   end

   // ---------------------------------------------------------------
   // per-pin drive request
   // ---------------------------------------------------------------
   logic [PINS-1:0] drive_en;
   logic [PINS-1:0] drive_val;

   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++)
      begin : g_pin
         if (gi == sixio_pkg::TOP_PIN)
         begin : g_top
            // serial clock overrides the general function
            always_comb
            begin
               if (hw_standby)
               begin
                  drive_en[gi]  = 1'b0;
                  drive_val[gi] = 1'b0;
               end
               else if (top_sck_input)
               begin
                  drive_en[gi]  = 1'b0;
                  drive_val[gi] = 1'b0;
               end
               else if (top_sck_output)
               begin
                  drive_en[gi]  = 1'b1;
                  drive_val[gi] = serial_clock_ch1_out;
               end
               else
               begin
                  drive_en[gi]  = st_reg.pin_direction[gi];
                  drive_val[gi] = st_reg.output_value[gi];
               end
            end
         end
         else
         begin : g_plain
            // other serial functions of these pins are not muxed here
            always_comb
            begin
               drive_en[gi]  = st_reg.pin_direction[gi] & ~hw_standby;
               drive_val[gi] = st_reg.output_value[gi];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;

      // bus answer: pready high for exactly the first access cycle
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      if (setup_phase)
      begin
         st_next.pready  = 1'b1;
         st_next.pslverr = ~hit_any;
         st_next.prdata  = '0;
         if (hit_direction)
         begin
            // stored direction is never returned
            st_next.prdata[sixio_pkg::REG_W-1:0] = sixio_pkg::DIRECTION_READ;
         end
         else if (hit_output)
         begin
            st_next.prdata[sixio_pkg::REG_W-1:0] =
               {sixio_pkg::RESERVED_READ, st_reg.output_value};
         end
         else if (hit_readback)
         begin
            st_next.prdata[sixio_pkg::REG_W-1:0] =
               {sixio_pkg::RESERVED_READ, st_reg.readback};
         end
         else if (hit_open_drain)
         begin
            st_next.prdata[sixio_pkg::REG_W-1:0] =
               {sixio_pkg::RESERVED_READ, st_reg.open_drain_select};
         end
      end

      // register writes; bits 7 and 6 are simply not stored
      if (low_lane_write)
      begin
         if (hit_direction)
         begin
            st_next.pin_direction = pwdata[PINS-1:0];
         end
         if (hit_output)
         begin
            st_next.output_value = pwdata[PINS-1:0];
         end
         if (hit_open_drain)
         begin
            st_next.open_drain_select = pwdata[PINS-1:0];
         end
         // readback is read-only, a write there is dropped quietly
      end

      // hardware standby clears; manual reset and software standby keep
      if (hw_standby)
      begin
         st_next.pin_direction     = sixio_pkg::DIRECTION_RST;
         st_next.output_value      = sixio_pkg::OUTPUT_RST;
         st_next.open_drain_select = sixio_pkg::OPEN_DRAIN_RST;
      end

      // readback snapshot; frozen so it survives manual reset and software standby
      if (!manual_reset && !sw_standby)
      begin
         st_next.readback = (st_reg.pin_direction & st_reg.output_value)
                          | (~st_reg.pin_direction & pin_level);
      end

      // pad drive; open drain only ever pulls low
      for (int i = 0; i < PINS; i++)
      begin
         if (!drive_en[i])
         begin
            st_next.pin_out[i] = 1'b0;
            st_next.pin_oe[i]  = 1'b0;
         end
         else if (st_reg.open_drain_select[i])
         begin
            st_next.pin_out[i] = 1'b0;
            st_next.pin_oe[i]  = ~drive_val[i];
         end
         else
         begin
            st_next.pin_out[i] = drive_val[i];
            st_next.pin_oe[i]  = 1'b1;
         end
      end

      // top pin level always reaches the interrupt logic
      st_next.irq_b  = pin_level[sixio_pkg::TOP_PIN];
      // serial clock input idles high when the pin is not selected
      st_next.sck_in = top_sck_input ? pin_level[sixio_pkg::TOP_PIN] : 1'b1;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // power-on reset clears everything but sck_in and irq_b, which start high; clock enable freezes all state
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg                   <= '0;
         st_reg.pin_direction     <= sixio_pkg::DIRECTION_RST;
         st_reg.output_value      <= sixio_pkg::OUTPUT_RST;
         st_reg.open_drain_select <= sixio_pkg::OPEN_DRAIN_RST;
         st_reg.readback          <= sixio_pkg::READBACK_RST;
         st_reg.sck_in            <= 1'b1;
         st_reg.irq_b             <= 1'b1;
      end
      else if (clock_enable)
      begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs, all straight from the state register
   // ---------------------------------------------------------------
   assign pready                    = st_reg.pready;
   assign prdata                    = st_reg.prdata;
   assign pslverr                   = st_reg.pslverr;
   assign pin_out                   = st_reg.pin_out;
   assign pin_oe                    = st_reg.pin_oe;
   assign serial_clock_ch1_in       = st_reg.sck_in;
   assign external_interrupt_line_b = st_reg.irq_b;

endmodule // sixio_port

// ---- testbench/sixio_board.sv ----
`timescale 1ns/1ps
module sixio_board (
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe,
   input  wire logic [5:0] ext_en,
   input  wire logic [5:0] ext_val,
   output logic      [5:0] pin_in
);
   // -----------------------------------------
   // pad resolution
   // -----------------------------------------
   // board yields to a driven pad, so the interrupt source never fights an output
   // released and undriven pads float up through the pull-up
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule // sixio_board

// ---- testbench/sixio_chk.sv ----
`timescale 1ns/1ps
module sixio_chk #(
   parameter int unsigned PINS = 6
) (
   input wire logic            clock,
   input wire logic            rst_n,
   input wire logic            clock_enable,
   input wire logic            hw_standby,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [19:0]     paddr,
   input wire logic [31:0]     prdata,
   input wire logic            serial_init,
   input wire logic            clock_enable_low,
   input wire logic            clock_enable_high,
   input wire logic            async_sync_select,
   input wire logic            serial_clock_ch1_out,
   input wire logic            serial_clock_ch1_in,
   input wire logic            external_interrupt_line_b,
   input wire logic [PINS-1:0] pin_in,
   input wire logic [PINS-1:0] pin_out,
   input wire logic [PINS-1:0] pin_oe
);
   // -----------------------------------------
   // helpers
   // -----------------------------------------
   logic rd_setup;
   logic mux_live;

   // read setup cycle; top pin mux not overridden by standby or init
   assign rd_setup = psel & ~penable & ~pwrite;
   assign mux_live = clock_enable & ~hw_standby & ~serial_init;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // -----------------------------------------
   // assertions
   // -----------------------------------------
   a_out_needs_oe: assert property ((pin_out & ~pin_oe) == '0)
      else $error("pad high while released");
   a_standby_release: assert property (hw_standby && clock_enable |=> pin_oe == '0)
      else $error("standby left a pad driven");
   a_sck_input: assert property (mux_live && clock_enable_high |=> !pin_oe[PINS-1])
      else $error("top pin driven in clock input mode");
   a_sck_output: assert property (mux_live && !clock_enable_high && (async_sync_select || clock_enable_low)
      |=> (pin_oe[PINS-1] ? pin_out[PINS-1] : 1'b1) == $past(serial_clock_ch1_out))
      else $error("top pin does not carry serial clock");
   a_sck_idle: assert property (clock_enable && (serial_init || !clock_enable_high) |=> serial_clock_ch1_in)
      else $error("clock input not idle");
   // synchroniser plus filter needs five edges, eight stable cycles leave margin
   a_irq_follow: assert property ((clock_enable && $stable(pin_in[PINS-1]))[*8]
      |-> external_interrupt_line_b == pin_in[PINS-1])
      else $error("interrupt line not following top pin");
   a_dir_read: assert property (rd_setup && paddr == sixio_pkg::ADDR_PIN_DIRECTION
      |=> prdata[7:0] == sixio_pkg::DIRECTION_READ)
      else $error("direction read value wrong");
   a_reserved_zero: assert property (rd_setup && paddr != sixio_pkg::ADDR_PIN_DIRECTION
      |=> prdata[7:6] == sixio_pkg::RESERVED_READ)
      else $error("reserved bits not zero");

   c_sck_input: cover property (mux_live && clock_enable_high);
   c_standby: cover property (hw_standby);
   c_dir_read: cover property (rd_setup && paddr == sixio_pkg::ADDR_PIN_DIRECTION);
endmodule // sixio_chk

bind sixio_port sixio_chk #(.PINS(PINS)) i_chk (.clock, .rst_n, .clock_enable, .hw_standby, .psel, .penable,
   .pwrite, .paddr, .prdata, .serial_init, .clock_enable_low, .clock_enable_high, .async_sync_select,
   .serial_clock_ch1_out, .serial_clock_ch1_in, .external_interrupt_line_b, .pin_in, .pin_out, .pin_oe);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   localparam logic [19:0] A_DIR = sixio_pkg::ADDR_PIN_DIRECTION;
   localparam logic [19:0] A_RB  = sixio_pkg::ADDR_PIN_LEVEL_READBACK;
   localparam logic [19:0] A_OUT = sixio_pkg::ADDR_OUTPUT_VALUE;
   localparam logic [19:0] A_ODR = sixio_pkg::ADDR_OPEN_DRAIN_SELECT;
   logic        clock, rst_n, clock_enable, manual_reset, hw_standby, sw_standby;
   logic        psel, penable, pwrite, pready, pslverr, er, serial_init;
   logic        clock_enable_low, clock_enable_high, async_sync_select;
   logic        serial_clock_ch1_out, serial_clock_ch1_in, external_interrupt_line_b;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [5:0]  pin_in, pin_out, pin_oe, ext_en, ext_val;
   int          n_fail, tests_run;

   sixio_port i_dut (.clock, .rst_n, .clock_enable, .manual_reset, .hw_standby, .sw_standby, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .serial_init, .clock_enable_low,
      .clock_enable_high, .async_sync_select, .serial_clock_ch1_out, .serial_clock_ch1_in,
      .external_interrupt_line_b, .pin_in, .pin_out, .pin_oe);
   sixio_board i_board (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);

   // -----------------------------------------
   // clock and tasks
   // -----------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen
   task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clock);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      if (k == 16)
      begin
         n_fail++;
         $display("[FAIL] %0t no ready", $time);
         give_verdict;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [19:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // settled sampling point, away from the launching edge
   task automatic look(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   initial
   begin
      {rst_n, manual_reset, hw_standby, sw_standby, psel, penable, pwrite} = '0;
      {clock_enable_low, clock_enable_high, async_sync_select, serial_clock_ch1_out} = '0;
      {clock_enable, serial_init, paddr, pwdata, pstrb} = {2'b11, 56'h0};
      {ext_en, ext_val, n_fail, tests_run} = {12'hFAA, 64'h0};
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      look(8);
      rdc(A_OUT, 32'h0);
      rdc(A_ODR, 32'h0);
      rdc(A_DIR, 32'hFF);
      // pin 0 has no board driver and floats up through its pull-up
      rdc(A_RB, 32'h2B);
      chk(pin_oe, 6'h00);
      // outputs are set through the direction and data registers
      xfer(1'b1, A_DIR, 32'h15);
      xfer(1'b1, A_OUT, 32'hC3);
      look(2);
      chk({pin_oe, pin_out}, 12'h541);
      rdc(A_OUT, 32'h03);
      rdc(A_RB, 32'h2B);
      xfer(1'b1, A_ODR, 32'hFF);
      look(2);
      chk({pin_oe, pin_out}, 12'h500);
      rdc(A_ODR, 32'h3F);
      // refused writes leave the data register alone
      xfer(1'b1, A_OUT, 32'h3C, 4'hE);
      xfer(1'b1, A_RB, 32'h3C);
      xfer(1'b0, 20'h0, 32'h0);
      chk(er, 1'b1);
      rdc(A_OUT, 32'h03);
      // manual reset then software standby: registers kept, readback frozen
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clock);
         manual_reset <= (k == 0);
         sw_standby <= (k == 1);
         ext_val <= k ? 6'h2A : 6'h00;
         look(8);
         rdc(A_RB, k ? 32'h01 : 32'h2B);
         rdc(A_OUT, 32'h03);
         rdc(A_ODR, 32'h3F);
         chk(pin_oe, 6'h14);
         @(posedge clock);
         {manual_reset, sw_standby} <= 2'b00;
         look(8);
         rdc(A_RB, k ? 32'h2B : 32'h01);
      end
      @(posedge clock);
      hw_standby <= 1'b1;
      look(2);
      chk(pin_oe, 6'h00);
      @(posedge clock);
      hw_standby <= 1'b0;
      look(8);
      rdc(A_OUT, 32'h0);
      rdc(A_ODR, 32'h0);
      rdc(A_RB, 32'h2B);
      chk(pin_oe, 6'h00);
      // top pin mux over every mode bit combination
      xfer(1'b1, A_DIR, 32'h20);
      xfer(1'b1, A_OUT, 32'h20);
      @(posedge clock);
      serial_init <= 1'b0;
      ext_val <= 6'h0A;
      for (int m = 0; m < 8; m++)
      begin
         @(posedge clock);
         {clock_enable_high, async_sync_select, clock_enable_low} <= m[2:0];
         look(8);
         chk({pin_oe[5], pin_out[5], serial_clock_ch1_in, external_interrupt_line_b},
             m[2] ? 4'h0 : (m[1:0] != 2'h0) ? 4'hA : 4'hF);
      end
      xfer(1'b1, A_ODR, 32'h20);
      @(posedge clock);
      {clock_enable_high, async_sync_select, clock_enable_low} <= 3'b001;
      serial_clock_ch1_out <= 1'b1;
      look(2);
      chk({pin_oe[5], pin_out[5]}, 2'b00);
      @(posedge clock);
      serial_clock_ch1_out <= 1'b0;
      look(1);
      chk({pin_oe[5], pin_out[5]}, 2'b10);
      // clock enable low freezes the pads even against a standby request
      @(posedge clock);
      clock_enable <= 1'b0;
      hw_standby <= 1'b1;
      look(2);
      chk(pin_oe[5], 1'b1);
      @(posedge clock);
      clock_enable <= 1'b1;
      hw_standby <= 1'b0;
      look(2);
      give_verdict;
   end
endmodule // tb_top
